// File: common/stack_monitor_params.svh
/*
  Constants of the stack monitor chain port: configuration layout and
  reset values, serial frame positions and watchdog timing.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef STACK_MONITOR_PARAMS_SVH
`define STACK_MONITOR_PARAMS_SVH

// Core clock rate in hertz
`define CORE_CLK_HZ 50000000
// Watchdog timeout in milliseconds
`define WDT_TIMEOUT_MS 2500
// Watchdog timeout in core cycles, rounded down
`define WDT_CYCLES (`WDT_TIMEOUT_MS * (`CORE_CLK_HZ / 1000))

// Configuration defaults: GPIO released, every discharge switch off
`define CFG_GPIO_DEFAULT 2'h3
`define CFG_DISCHARGE_DEFAULT 12'h000
// Number of balancing outputs
`define CELL_COUNT 12

// Frame positions, counted from chip select falling in bits or in bytes as the names say
`define CFG_LAST_BYTE 3'h1
`define STATUS_BITS 6'h20
`define FWD_LAST_POS 6'h20
`define LAST_BIT 3'h7
`define BYTE_CNT_MAX 3'h7

`endif

// File: common/stack_monitor_pkg.sv
/*
  Types of the stack monitor chain port.
  Assumes the constants header sits beside it on the include path.
*/
`include "stack_monitor_params.svh"

package stack_monitor_pkg;

  // Configuration held for the host
  typedef struct packed {
    logic [1:0] gpio;
    logic [11:0] discharge;
  } cfg_t;

  // Snapshot shifted out on the serial data output
  typedef struct packed {
    logic mark;
    logic monitor;
    logic watchdog;
    logic top;
    logic volt;
    logic unused;
    logic gp_two;
    logic gp_one;
    logic [11:0] temp_one;
    logic [11:0] temp_two;
  } status_t;

endpackage

// File: hw/stack_monitor_chain_port.sv
/*
  Serial chain port of a stackable cell monitor: chip select and clock
  forwarding, chain data relay, configuration capture, watchdog,
  open-drain GPIO and watchdog pins, discharge control and readout of
  the temperature results.
  Assumes pins arrive asynchronous to CORE_CLK, the serial clock only
  toggles while chip select is low, and straps are static.
*/
`timescale 1ns/10ps
`default_nettype none
`include "stack_monitor_params.svh"
module stack_monitor_chain_port
  import stack_monitor_pkg::*;
#(
  // Watchdog idle time in core cycles
  parameter int unsigned WDT_CYCLES = `WDT_CYCLES
) (
  // Core clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  // Main side serial port
  input wire logic SERIAL_CLOCK_IN,
  input wire logic CHIP_SELECT_IN_N,
  input wire logic SERIAL_DATA_IN,
  output var logic SERIAL_DATA_OUT_OE,
  // Chain side toward the device above
  output var logic CHIP_SELECT_OUT_N,
  output var logic SERIAL_CLOCK_OUT,
  input wire logic CHAIN_DATA_IN,
  output var logic CHAIN_DATA_OUT,
  output var logic CHAIN_DATA_OE,
  // Straps
  input wire logic TOP_OF_STACK_STRAP,
  input wire logic SIGNAL_LEVEL_STRAP,
  input wire logic MONITOR_MODE_N,
  // Open-drain watchdog pin
  input wire logic WATCHDOG_TIMEOUT_N_IN,
  output var logic WATCHDOG_TIMEOUT_N_OE,
  // Open-drain general purpose pins
  input wire logic GP_PIN_ONE_IN,
  output var logic GP_PIN_ONE_OE,
  input wire logic GP_PIN_TWO_IN,
  output var logic GP_PIN_TWO_OE,
  // Balancing and monitor mode
  output var logic [11:0] DISCHARGE_ON,
  output var logic MONITOR_ACTIVE,
  output var logic [2:0] MONITOR_CELL_SEL,
  // Temperature conversion results from the converter
  input wire logic [11:0] TEMP_ONE_CODE,
  input wire logic [11:0] TEMP_TWO_CODE,
  input wire logic TEMP_VALID
);

  // Core-domain synchronisers, first and second stage
  logic cs_meta_reg, cs_sync_reg;
  logic sck_meta_reg, sck_sync_reg;
  logic top_meta_reg, top_sync_reg;
  logic volt_meta_reg, volt_sync_reg;
  logic mon_meta_reg, mon_sync_reg;
  logic wd_meta_reg, wd_sync_reg;
  logic gp1_meta_reg, gp1_sync_reg;
  logic gp2_meta_reg, gp2_sync_reg;
  // Previous clock level, for activity detection
  logic sck_prev_reg;
  // Configuration crossing toggle, three stages
  logic cfg_tog_meta_reg, cfg_tog_sync_reg, cfg_tog_seen_reg;

  // Core state
  cfg_t cfg_reg, cfg_next;
  logic [31:0] wdt_cnt_reg, wdt_cnt_next;
  logic watchdog_reg;
  logic [11:0] temp_one_reg, temp_two_reg;
  status_t snap_reg;

  // Link-domain state
  logic [2:0] bit_cnt_reg;
  logic [2:0] byte_cnt_reg;
  logic [7:0] shift_reg;
  logic chain_rx_reg;
  logic [5:0] cfg_hi_reg;
  cfg_t cfg_hold_reg;
  logic cfg_tog_reg;

  // Decoded conditions
  wire logic link_rst_n;
  wire logic sck_activity;
  wire logic wdt_expired;
  wire logic cfg_arrived;
  wire logic normal_mode;
  wire logic [5:0] pos;
  wire logic fwd_phase;
  wire logic tx_bit;
  wire logic last_bit;
  wire logic sdi_now;
  status_t snap_next;

  // Chip select high holds the link receive and transmit logic in reset, so a partial byte
  // never survives a deselect; the clock is stopped then anyway
  assign link_rst_n = RESET_N & ~CHIP_SELECT_IN_N;
  // Any clock edge seen in the core domain counts as host activity
  assign sck_activity = sck_sync_reg ^ sck_prev_reg;
  assign wdt_expired = (wdt_cnt_reg >= WDT_CYCLES - 1);
  assign cfg_arrived = cfg_tog_sync_reg ^ cfg_tog_seen_reg;
  assign normal_mode = mon_sync_reg;
  // Bit position inside the frame, bytes above seven saturate
  assign pos = {byte_cnt_reg, bit_cnt_reg};
  assign last_bit = (bit_cnt_reg == `LAST_BIT);
  assign sdi_now = SERIAL_DATA_IN;
  // Write data goes up while the host is still sending the first bytes
  assign fwd_phase = (pos <= `FWD_LAST_POS);
  // Own status first, then whatever the chain returns
  assign tx_bit = (pos < `STATUS_BITS) ? snap_reg[~pos[4:0]] :
                  (top_sync_reg | chain_rx_reg);

  // Status snapshot; pin levels show what the pins really carry
  assign snap_next = '{mark: 1'b1,
                       monitor: ~mon_sync_reg,
                       watchdog: watchdog_reg,
                       top: top_sync_reg,
                       volt: volt_sync_reg,
                       unused: 1'b0,
                       gp_two: gp2_sync_reg,
                       gp_one: gp1_sync_reg,
                       temp_one: temp_one_reg,
                       temp_two: temp_two_reg};

  // Next configuration: watchdog default wins over a new host write
  always_comb begin
    cfg_next = cfg_reg;
    if (watchdog_reg) begin
      cfg_next.gpio = `CFG_GPIO_DEFAULT;
      cfg_next.discharge = `CFG_DISCHARGE_DEFAULT;
    end else if (cfg_arrived) begin
      cfg_next = cfg_hold_reg;
    end
  end

  // Idle counter restarts on every clock edge and holds once expired
  always_comb begin
    if (sck_activity) begin
      wdt_cnt_next = 32'h0000_0000;
    end else if (wdt_expired) begin
      wdt_cnt_next = wdt_cnt_reg;
    end else begin
      wdt_cnt_next = wdt_cnt_reg + 32'h0000_0001;
    end
  end

  // Two-flop synchronisers for every pin read by core logic
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      {cs_meta_reg, cs_sync_reg} <= 2'h3;
      {sck_meta_reg, sck_sync_reg} <= 2'h0;
      {top_meta_reg, top_sync_reg} <= 2'h0;
      {volt_meta_reg, volt_sync_reg} <= 2'h0;
      {mon_meta_reg, mon_sync_reg} <= 2'h3;
      {wd_meta_reg, wd_sync_reg} <= 2'h3;
      {gp1_meta_reg, gp1_sync_reg} <= 2'h3;
      {gp2_meta_reg, gp2_sync_reg} <= 2'h3;
    end else begin
      {cs_meta_reg, cs_sync_reg} <= {CHIP_SELECT_IN_N, cs_meta_reg};
      {sck_meta_reg, sck_sync_reg} <= {SERIAL_CLOCK_IN, sck_meta_reg};
      {top_meta_reg, top_sync_reg} <= {TOP_OF_STACK_STRAP, top_meta_reg};
      {volt_meta_reg, volt_sync_reg} <= {SIGNAL_LEVEL_STRAP, volt_meta_reg};
      {mon_meta_reg, mon_sync_reg} <= {MONITOR_MODE_N, mon_meta_reg};
      {wd_meta_reg, wd_sync_reg} <= {WATCHDOG_TIMEOUT_N_IN, wd_meta_reg};
      {gp1_meta_reg, gp1_sync_reg} <= {GP_PIN_ONE_IN, gp1_meta_reg};
      {gp2_meta_reg, gp2_sync_reg} <= {GP_PIN_TWO_IN, gp2_meta_reg};
    end
  end

  // Configuration toggle crossing from the link domain
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cfg_tog_meta_reg <= 1'b0;
      cfg_tog_sync_reg <= 1'b0;
      cfg_tog_seen_reg <= 1'b0;
    end else begin
      cfg_tog_meta_reg <= cfg_tog_reg;
      cfg_tog_sync_reg <= cfg_tog_meta_reg;
      cfg_tog_seen_reg <= cfg_tog_sync_reg;
    end
  end

  // Watchdog counter and flag
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sck_prev_reg <= 1'b0;
      wdt_cnt_reg <= 32'h0000_0000;
      watchdog_reg <= 1'b0;
    end else begin
      sck_prev_reg <= sck_sync_reg;
      wdt_cnt_reg <= wdt_cnt_next;
      watchdog_reg <= wdt_expired & ~sck_activity;
    end
  end

  // Configuration and temperature result registers
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cfg_reg <= '{gpio: `CFG_GPIO_DEFAULT, discharge: `CFG_DISCHARGE_DEFAULT};
      temp_one_reg <= 12'h000;
      temp_two_reg <= 12'h000;
    end else begin
      cfg_reg <= cfg_next;
      if (TEMP_VALID) begin
        temp_one_reg <= TEMP_ONE_CODE;
        temp_two_reg <= TEMP_TWO_CODE;
      end
    end
  end

  // Snapshot only moves while deselected, so the link reads a still
  // word; the first sampled bit lies at least one clock high after select
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      snap_reg <= '0;
    end else if (cs_sync_reg) begin
      snap_reg <= snap_next;
    end
  end

  // Forwarded select and clock; a resynchronised copy adds latency
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CHIP_SELECT_OUT_N <= 1'b1;
      SERIAL_CLOCK_OUT <= 1'b0;
    end else begin
      CHIP_SELECT_OUT_N <= cs_sync_reg;
      SERIAL_CLOCK_OUT <= sck_sync_reg;
    end
  end

  // Pin drivers, discharge and monitor outputs
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      GP_PIN_ONE_OE <= 1'b0;
      GP_PIN_TWO_OE <= 1'b0;
      WATCHDOG_TIMEOUT_N_OE <= 1'b0;
      DISCHARGE_ON <= `CFG_DISCHARGE_DEFAULT;
      MONITOR_ACTIVE <= 1'b0;
      MONITOR_CELL_SEL <= 3'h0;
    end else begin
      // Pull-down on a zero bit, released on a one
      GP_PIN_ONE_OE <= normal_mode & ~cfg_reg.gpio[0];
      GP_PIN_TWO_OE <= normal_mode & ~cfg_reg.gpio[1];
      // In monitor mode the watchdog pin becomes an input
      WATCHDOG_TIMEOUT_N_OE <= normal_mode & watchdog_reg;
      DISCHARGE_ON <= cfg_reg.discharge;
      MONITOR_ACTIVE <= ~normal_mode;
      MONITOR_CELL_SEL <= normal_mode ? 3'h0 :
                          {wd_sync_reg, gp2_sync_reg, gp1_sync_reg};
    end
  end

  // Link receive: sample on the rising clock, MSB first
  always_ff @(posedge SERIAL_CLOCK_IN or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt_reg <= 3'h0;
      byte_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      chain_rx_reg <= 1'b1;
    end else begin
      shift_reg <= {shift_reg[6:0], sdi_now};
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (last_bit && byte_cnt_reg != `BYTE_CNT_MAX) begin
        byte_cnt_reg <= byte_cnt_reg + 3'h1;
      end
      // Read data coming down from the device above
      chain_rx_reg <= CHAIN_DATA_IN;
    end
  end

  // Completed configuration bytes; reset only by the core reset so the
  // toggle keeps its meaning across frames
  always_ff @(posedge SERIAL_CLOCK_IN or negedge RESET_N) begin
    if (!RESET_N) begin
      cfg_hi_reg <= 6'h00;
      cfg_hold_reg <= '{gpio: `CFG_GPIO_DEFAULT, discharge: `CFG_DISCHARGE_DEFAULT};
      cfg_tog_reg <= 1'b0;
    end else if (!CHIP_SELECT_IN_N && last_bit) begin
      if (byte_cnt_reg == 3'h0) begin
        // First byte: GPIO bits on top, discharge bits 11..8 below
        cfg_hi_reg <= {shift_reg[6:5], shift_reg[2:0], sdi_now};
      end else if (byte_cnt_reg == `CFG_LAST_BYTE) begin
        cfg_hold_reg <= {cfg_hi_reg, shift_reg[6:0], sdi_now};
        cfg_tog_reg <= ~cfg_tog_reg;
      end
    end
  end

  // Link transmit: change on the falling clock; the idle state of the
  // output is released, which presents the leading marker bit
  always_ff @(negedge SERIAL_CLOCK_IN or negedge link_rst_n) begin
    if (!link_rst_n) begin
      SERIAL_DATA_OUT_OE <= 1'b0;
      CHAIN_DATA_OUT <= 1'b0;
      CHAIN_DATA_OE <= 1'b0;
    end else begin
      // Pull-down only, and silent in current mode
      SERIAL_DATA_OUT_OE <= volt_sync_reg & ~tx_bit;
      // Write data up the chain unless this is the top device
      CHAIN_DATA_OUT <= shift_reg[0];
      CHAIN_DATA_OE <= ~top_sync_reg & fwd_phase;
    end
  end

  // Select out goes low one edge after the synchronised select falls
  property p_cs_follow;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    $fell(cs_sync_reg) |=> !CHIP_SELECT_OUT_N;
  endproperty
  a_cs_follow: assert property (p_cs_follow) else $error("select not forwarded");

  // Clock out toggles one edge after every clock edge seen by the core
  property p_sck_follow;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    sck_activity |=> (SERIAL_CLOCK_OUT != $past(SERIAL_CLOCK_OUT));
  endproperty
  a_sck_follow: assert property (p_sck_follow) else $error("clock not forwarded");

  // Watchdog rises only after the full idle count
  property p_wdt_time;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    $rose(watchdog_reg) |-> ($past(wdt_cnt_reg) >= WDT_CYCLES - 1);
  endproperty
  a_wdt_time: assert property (p_wdt_time) else $error("watchdog early");

  // Watchdog clears the switches and releases the GPIOs
  property p_wdt_default;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    watchdog_reg |=> ##1 (DISCHARGE_ON == `CFG_DISCHARGE_DEFAULT)
                        && (cfg_reg.gpio == `CFG_GPIO_DEFAULT);
  endproperty
  a_wdt_default: assert property (p_wdt_default) else $error("config kept");

  // Watchdog pin pulls in normal mode while asserted
  property p_wdt_pin;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    (watchdog_reg && normal_mode) |=> WATCHDOG_TIMEOUT_N_OE;
  endproperty
  a_wdt_pin: assert property (p_wdt_pin) else $error("watchdog pin idle");

  // GPIO zero pulls the pin low in normal mode
  property p_gp_pull;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    (normal_mode && !cfg_reg.gpio[0]) |=> GP_PIN_ONE_OE;
  endproperty
  a_gp_pull: assert property (p_gp_pull) else $error("gpio not pulled");

  // GPIO one leaves the pin released
  property p_gp_release;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    cfg_reg.gpio[1] |=> !GP_PIN_TWO_OE;
  endproperty
  a_gp_release: assert property (p_gp_release) else $error("gpio driven");

  // Monitor mode drives none of the selection pins
  property p_monitor_inputs;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    !normal_mode |=> !GP_PIN_ONE_OE && !GP_PIN_TWO_OE && !WATCHDOG_TIMEOUT_N_OE
                     && MONITOR_ACTIVE;
  endproperty
  a_monitor_inputs: assert property (p_monitor_inputs) else $error("monitor pins driven");

  // Top device never drives the chain pin
  property p_top_quiet;
    @(negedge SERIAL_CLOCK_IN) disable iff (!link_rst_n)
    top_sync_reg |=> !CHAIN_DATA_OE;
  endproperty
  a_top_quiet: assert property (p_top_quiet) else $error("top drives chain");

  // Current mode leaves the data output unused
  property p_current_quiet;
    @(negedge SERIAL_CLOCK_IN) disable iff (!link_rst_n)
    !volt_sync_reg |=> !SERIAL_DATA_OUT_OE;
  endproperty
  a_current_quiet: assert property (p_current_quiet) else $error("output used");

endmodule

`default_nettype wire

// File: tb/chain_host_model.sv
/*
  Host and upper-neighbour model for the chain port bench.
  Assumes the bench turns open-drain enables into pin levels and calls
  xfer between tests; the serial clock stands still outside frames.
*/
`timescale 1ns/10ps
`default_nettype none

module chain_host_model (
  // Host serial drive
  output logic sck,
  output logic cs_n,
  output logic serial_data_in,
  input wire logic sdo_level,
  // Forwarded select and clock
  input wire logic cs_up_n,
  input wire logic sck_up,
  // Chain pin and the device above
  input wire logic chain_oe,
  input wire logic chain_out,
  input wire logic upper_bit,
  output logic chain_level
);
  int fwd_cnt;      // Bits driven upward in this frame
  int fwd_bad;      // Forwarded select or clock seen wrong
  logic [31:0] fwd; // Bits captured by the device above

  // Upper device answers only while selected; a released line shows stale inverse
  assign chain_level = chain_oe ? chain_out : (cs_up_n ? ~chain_out : upper_bit);

  // Upper device samples the chain pin on the rising clock
  always @(posedge sck) begin
    if (chain_oe) begin
      fwd = {fwd[30:0], chain_out};
      fwd_cnt++;
    end
  end

  // Idle levels at time zero
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    serial_data_in = 1'b1;
    fwd = '0;
    fwd_cnt = 0;
    fwd_bad = 0;
  end

  // One frame, MSB first; hold stretches both phases for a slow host
  task automatic xfer(input int nbits, input logic [39:0] tx, input int hold,
                      output logic [39:0] rx);
    int i;
    rx = '0;
    fwd_cnt = 0;
    cs_n = 1'b0;
    #100;
    if (cs_up_n !== 1'b0) fwd_bad++;
    for (i = 0; i < nbits; i++) begin
      serial_data_in = tx[39 - i];
      #(15 + hold);
      if (hold > 60 && sck_up !== 1'b0) fwd_bad++;
      sck = 1'b1;
      rx = {rx[38:0], sdo_level};
      #(15 + hold);
      if (hold > 60 && sck_up !== 1'b1) fwd_bad++;
      sck = 1'b0;
    end
    // Released data line shows the inverse, never the last bit
    serial_data_in = ~serial_data_in;
    #100;
    cs_n = 1'b1;
    #100;
    if (cs_up_n !== 1'b1) fwd_bad++;
  endtask
endmodule

`default_nettype wire

// File: tb/stack_monitor_chain_port_test.sv
/*
  Self-checking bench of the chain port: config writes, readback,
  relay, straps, monitor mode and watchdog.
  Assumes the host model file is compiled before this one.
*/
`timescale 1ns/10ps
`default_nettype none

module stack_monitor_chain_port_test;
  import stack_monitor_pkg::*;
  localparam logic [11:0] T1 = 12'h3C5; // Temperature one code
  localparam logic [11:0] T2 = 12'hA1F; // Temperature two code

  logic CORE_CLK, RESET_N, TOP, LEVEL, MON_N, TEMP_VALID, upper_bit, wdt_ext;
  logic [11:0] TEMP_ONE_CODE, TEMP_TWO_CODE, DISCHARGE_ON, dis;
  logic [1:0] gp_ext, gp;
  logic [2:0] MONITOR_CELL_SEL;
  logic [39:0] rx, fw;
  logic SDO_OE, CS_OUT_N, SCK_OUT, CH_OUT, CH_OE, WDT_OE, GP1_OE, GP2_OE, MON;
  wire sck, cs_n, serial_data_in, chain_level;
  int err_count, checks, k;

  // Open-drain pins with pull-ups: low while enabled, else the outside level
  wire sdo_level = ~SDO_OE;
  wire gp1_lvl = GP1_OE ? 1'b0 : gp_ext[0];
  wire gp2_lvl = GP2_OE ? 1'b0 : gp_ext[1];
  wire wdt_lvl = WDT_OE ? 1'b0 : wdt_ext;

  stack_monitor_chain_port #(.WDT_CYCLES(200)) dut (
    .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .SERIAL_CLOCK_IN(sck),
    .CHIP_SELECT_IN_N(cs_n), .SERIAL_DATA_IN(serial_data_in), .SERIAL_DATA_OUT_OE(SDO_OE),
    .CHIP_SELECT_OUT_N(CS_OUT_N), .SERIAL_CLOCK_OUT(SCK_OUT),
    .CHAIN_DATA_IN(chain_level), .CHAIN_DATA_OUT(CH_OUT), .CHAIN_DATA_OE(CH_OE),
    .TOP_OF_STACK_STRAP(TOP), .SIGNAL_LEVEL_STRAP(LEVEL), .MONITOR_MODE_N(MON_N),
    .WATCHDOG_TIMEOUT_N_IN(wdt_lvl), .WATCHDOG_TIMEOUT_N_OE(WDT_OE),
    .GP_PIN_ONE_IN(gp1_lvl), .GP_PIN_ONE_OE(GP1_OE), .GP_PIN_TWO_IN(gp2_lvl),
    .GP_PIN_TWO_OE(GP2_OE), .DISCHARGE_ON(DISCHARGE_ON), .MONITOR_ACTIVE(MON),
    .MONITOR_CELL_SEL(MONITOR_CELL_SEL), .TEMP_ONE_CODE(TEMP_ONE_CODE),
    .TEMP_TWO_CODE(TEMP_TWO_CODE), .TEMP_VALID(TEMP_VALID));

  chain_host_model host (
    .sck(sck), .cs_n(cs_n), .serial_data_in(serial_data_in), .sdo_level(sdo_level), .cs_up_n(CS_OUT_N),
    .sck_up(SCK_OUT), .chain_oe(CH_OE), .chain_out(CH_OUT), .upper_bit(upper_bit),
    .chain_level(chain_level));

  // Compare and count; case inequality so unknowns never match
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  // Expected status word in voltage mode, normal operation
  function automatic logic [31:0] stat(input logic wd, input logic top, input logic [1:0] lv);
    return {1'b1, 1'b0, wd, top, 1'b1, 1'b0, lv, T1, T2};
  endfunction

  // Write frame: gpio byte, discharge bytes, then padding
  function automatic logic [39:0] cfg_frame(input logic [1:0] g, input logic [11:0] d);
    return {g, 2'b00, d, 24'h000000};
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Core clock, 20 ns period
  initial begin
    CORE_CLK = 1'b0;
    forever #10 CORE_CLK = ~CORE_CLK;
  end

  // Hang guard: the sequence needs well under 60 us
  initial begin
    #200000;
    err_count++;
    $display("[ERR] %0t run did not finish", $time);
    wrap_up();
  end

  // Main sequence
  initial begin
    RESET_N = 1'b0;
    TOP = 1'b0;
    LEVEL = 1'b1;
    MON_N = 1'b1;
    TEMP_VALID = 1'b0;
    TEMP_ONE_CODE = 12'h000;
    TEMP_TWO_CODE = 12'h000;
    upper_bit = 1'b0;
    wdt_ext = 1'b1;
    gp_ext = 2'b11;
    err_count = 0;
    checks = 0;
    repeat (20) @(posedge CORE_CLK);
    RESET_N <= 1'b1;
    repeat (4) @(posedge CORE_CLK);
    check(CS_OUT_N, 1'b1, "select out idle");
    check(DISCHARGE_ON, 12'h000, "discharge idle");
    check({GP2_OE, GP1_OE, WDT_OE, MON}, 4'h0, "pins idle");
    done("reset");
    TEMP_VALID <= 1'b1;
    TEMP_ONE_CODE <= T1;
    TEMP_TWO_CODE <= T2;
    @(posedge CORE_CLK);
    TEMP_VALID <= 1'b0;
    for (k = 0; k < 2; k++) begin
      @(posedge CORE_CLK);
      gp = k[0] ? 2'b10 : 2'b01;
      dis = k[0] ? 12'h5A3 : 12'hA5C;
      fw = cfg_frame(gp, dis);
      gp_ext <= k[0] ? 2'b10 : 2'b11;
      upper_bit <= k[0];
      host.xfer(40, fw, 0, rx);
      repeat (8) @(posedge CORE_CLK);
      check(DISCHARGE_ON, dis, "discharge");
      check({GP2_OE, GP1_OE}, 2'(~gp), "gpio drive");
      check(host.fwd, fw[39:8], "forwarded bits");
      check(host.fwd_cnt, 32, "forwarded count");
      check(rx[5:0], {6{k[0]}}, "relayed bits");
      host.xfer(40, fw, k * 100, rx);
      check(rx[39:8], stat(1'b0, 1'b0, gp & gp_ext), "status");
      done("write and read");
    end
    check(host.fwd_bad, 0, "select and clock copies");
    host.xfer(15, cfg_frame(2'b11, 12'hFFF), 0, rx);
    repeat (8) @(posedge CORE_CLK);
    check(DISCHARGE_ON, 12'h5A3, "partial frame");
    done("partial");
    upper_bit <= 1'b0;
    TOP <= 1'b1;
    repeat (4) @(posedge CORE_CLK);
    host.xfer(40, fw, 0, rx);
    check(host.fwd_cnt, 0, "top chain drive");
    check({rx[36], rx[5:0]}, 7'h7F, "top flag and tail");
    @(posedge CORE_CLK);
    TOP <= 1'b0;
    LEVEL <= 1'b0;
    repeat (4) @(posedge CORE_CLK);
    host.xfer(40, fw, 0, rx);
    check(rx[39:8], 32'hFFFFFFFF, "current mode output");
    @(posedge CORE_CLK);
    LEVEL <= 1'b1;
    done("straps");
    MON_N <= 1'b0;
    gp_ext <= 2'b01;
    repeat (8) @(posedge CORE_CLK);
    check(MON, 1'b1, "monitor flag");
    check(MONITOR_CELL_SEL, 3'h5, "cell select");
    check({GP2_OE, GP1_OE}, 2'h0, "monitor pins input");
    MON_N <= 1'b1;
    gp_ext <= 2'b11;
    done("monitor");
    host.xfer(40, cfg_frame(2'b00, 12'hFFF), 0, rx);
    repeat (150) @(posedge CORE_CLK);
    check({WDT_OE, DISCHARGE_ON}, 13'h0FFF, "before timeout");
    repeat (60) @(posedge CORE_CLK);
    check(WDT_OE, 1'b1, "watchdog pin");
    check(DISCHARGE_ON, 12'h000, "switches off");
    check({GP2_OE, GP1_OE}, 2'h0, "config default");
    host.xfer(40, cfg_frame(2'b11, 12'h000), 0, rx);
    check(rx[37], 1'b1, "watchdog status");
    done("watchdog");
    wrap_up();
  end
endmodule

`default_nettype wire
